// [rtl/mcd_decoder.sv]
`timescale 1ns/10ps
// Contract
// - Fields at bits 28:27, 26:24, 23:21, 20:16
// - AVC decode object, not interruptible
// - AVC forward quant matrix state, image level
// - AVC encoder bitstream insert object
// - AVC pack object interruptible; A-1Fh reserved
// - VC1 picture, prediction, direct-mode state mapping
// - VC1 decode object, interruptible
// - VC1 encode group entirely reserved
// - MPEG2 picture and quant matrix; rest reserved
// - MPEG2 decode object, interruptible
// - MPEG2 encode group entirely reserved
module mcd_decoder (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  hdr_valid,
  input  wire logic [mcd_pkg::HDR_W-1:0] hdr_data,
  output logic                       hdr_ready,
  output logic                       res_valid,
  input  wire logic                  res_ready,
  output mcd_pkg::mcd_result_t       res
);
  import mcd_pkg::*;

  logic        res_valid_reg;
  mcd_result_t res_reg;
  mcd_result_t res_next;

  function automatic mcd_fields_t split_header(input logic [HDR_W-1:0] h);
    mcd_fields_t f;
    f.pipe_type    = h[PIPE_TYPE_MSB:PIPE_TYPE_LSB];
    f.opcode       = h[OPCODE_MSB:OPCODE_LSB];
    f.sub_opcode_a = h[SUB_A_MSB:SUB_A_LSB];
    f.sub_opcode_b = h[SUB_B_MSB:SUB_B_LSB];
    return f;
  endfunction : split_header

  // Classifies one header. Groups outside this decoder's map are flagged
  // unhandled rather than invalid so another decoder can claim them.
  function automatic mcd_result_t classify(input logic [HDR_W-1:0] h);
    mcd_result_t r;
    mcd_fields_t f;
    logic        in_map;
    r             = '0;
    f             = split_header(h);
    in_map        = 1'b1;
    r.header      = h;
    r.cmd         = MCD_CMD_NONE;
    r.level       = MCD_LVL_NONE;
    if (f.pipe_type != PIPE_MEDIA) begin
      in_map = 1'b0;
    end else begin
      case (f.opcode)
        OPC_AVC: begin
          if (f.sub_opcode_a == GRP_DEC) begin
            if (f.sub_opcode_b == SUBB_OBJECT) begin
              r.cmd           = MCD_CMD_AVC_DECODE_OBJECT;
              r.interruptible = 1'b0;
            end
          end else if (f.sub_opcode_a == GRP_ENC) begin
            case (f.sub_opcode_b)
              SUBB_2: begin
                r.cmd   = MCD_CMD_AVC_ENC_FWD_QUANT_MATRIX_STATE;
                r.level = MCD_LVL_IMAGE;
              end
              SUBB_OBJECT: begin
                r.cmd = MCD_CMD_AVC_ENC_INSERT_OBJECT;
              end
              SUBB_PACK: begin
                r.cmd           = MCD_CMD_AVC_ENC_PACK_OBJECT;
                r.interruptible = 1'b1;
              end
              default: begin
                r.cmd = MCD_CMD_NONE;
              end
            endcase
          end else begin
            // AVC common state belongs to another decoder
            in_map = 1'b0;
          end
        end
        OPC_VC1: begin
          if (f.sub_opcode_a == GRP_COMMON) begin
            case (f.sub_opcode_b)
              SUBB_0: begin
                r.cmd   = MCD_CMD_VC1_PICTURE_STATE;
                r.level = MCD_LVL_IMAGE;
              end
              SUBB_1: begin
                r.cmd   = MCD_CMD_VC1_PREDICTION_PIPE_STATE;
                r.level = MCD_LVL_IMAGE;
              end
              SUBB_2: begin
                r.cmd   = MCD_CMD_VC1_DIRECT_MODE_STATE;
                r.level = MCD_LVL_SLICE;
              end
              default: begin
                r.cmd = MCD_CMD_NONE;
              end
            endcase
          end else if (f.sub_opcode_a == GRP_DEC) begin
            if (f.sub_opcode_b == SUBB_OBJECT) begin
              r.cmd           = MCD_CMD_VC1_DECODE_OBJECT;
              r.interruptible = 1'b1;
            end
          end else begin
            // Encode group and unlisted groups stay reserved
            r.cmd = MCD_CMD_NONE;
          end
        end
        OPC_MPEG2: begin
          if (f.sub_opcode_a == GRP_COMMON) begin
            case (f.sub_opcode_b)
              SUBB_0: begin
                r.cmd   = MCD_CMD_MPEG2_PICTURE_STATE;
                r.level = MCD_LVL_IMAGE;
              end
              SUBB_1: begin
                r.cmd   = MCD_CMD_MPEG2_QUANT_MATRIX_STATE;
                r.level = MCD_LVL_IMAGE;
              end
              default: begin
                r.cmd = MCD_CMD_NONE;
              end
            endcase
          end else if (f.sub_opcode_a == GRP_DEC) begin
            if (f.sub_opcode_b == SUBB_OBJECT) begin
              r.cmd           = MCD_CMD_MPEG2_DECODE_OBJECT;
              r.interruptible = 1'b1;
            end
          end else begin
            r.cmd = MCD_CMD_NONE;
          end
        end
        OPC_RSVD_4, OPC_RSVD_5, OPC_RSVD_7: begin
          r.cmd = MCD_CMD_NONE;
        end
        default: begin
          // Common and crypto maps are decoded elsewhere
          in_map = 1'b0;
        end
      endcase
    end
    r.unhandled = !in_map;
    r.invalid   = in_map && (r.cmd == MCD_CMD_NONE);
    r.start     = in_map && (r.cmd != MCD_CMD_NONE);
    return r;
  endfunction : classify

  // One result slot; a new header is taken while the slot drains
  assign hdr_ready = !res_valid_reg || res_ready;
  assign res_valid = res_valid_reg;
  assign res       = res_reg;

  always_comb begin
    res_next = classify(hdr_data);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid_reg <= RESET_VALID;
    end else if (hdr_ready) begin
      res_valid_reg <= hdr_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      res_reg <= '0;
    end else if (hdr_ready && hdr_valid) begin
      res_reg <= res_next;
    end
  end

endmodule : mcd_decoder

// [rtl/mcd_pkg.sv]
package mcd_pkg;

  // Header field positions
  localparam int PIPE_TYPE_MSB = 28;
  localparam int PIPE_TYPE_LSB = 27;
  localparam int OPCODE_MSB    = 26;
  localparam int OPCODE_LSB    = 24;
  localparam int SUB_A_MSB     = 23;
  localparam int SUB_A_LSB     = 21;
  localparam int SUB_B_MSB     = 20;
  localparam int SUB_B_LSB     = 16;

  localparam int HDR_W = 32;

  // Field values
  localparam logic [1:0] PIPE_MEDIA     = 2'h2;
  localparam logic [2:0] OPC_AVC        = 3'h1;
  localparam logic [2:0] OPC_VC1        = 3'h2;
  localparam logic [2:0] OPC_MPEG2      = 3'h3;
  localparam logic [2:0] OPC_RSVD_4     = 3'h4;
  localparam logic [2:0] OPC_RSVD_5     = 3'h5;
  localparam logic [2:0] OPC_RSVD_7     = 3'h7;
  localparam logic [2:0] GRP_COMMON     = 3'h0;
  localparam logic [2:0] GRP_DEC        = 3'h1;
  localparam logic [2:0] GRP_ENC        = 3'h2;
  localparam logic [4:0] SUBB_0         = 5'h00;
  localparam logic [4:0] SUBB_1         = 5'h01;
  localparam logic [4:0] SUBB_2         = 5'h02;
  localparam logic [4:0] SUBB_OBJECT    = 5'h08;
  localparam logic [4:0] SUBB_PACK      = 5'h09;

  // Reset value of the result valid flag
  localparam logic RESET_VALID = 1'b0;

  typedef enum logic [3:0] {
    MCD_CMD_NONE                           = 4'h0,
    MCD_CMD_AVC_DECODE_OBJECT              = 4'h1,
    MCD_CMD_AVC_ENC_FWD_QUANT_MATRIX_STATE = 4'h2,
    MCD_CMD_AVC_ENC_INSERT_OBJECT          = 4'h3,
    MCD_CMD_AVC_ENC_PACK_OBJECT            = 4'h4,
    MCD_CMD_VC1_PICTURE_STATE              = 4'h5,
    MCD_CMD_VC1_PREDICTION_PIPE_STATE      = 4'h6,
    MCD_CMD_VC1_DIRECT_MODE_STATE          = 4'h7,
    MCD_CMD_VC1_DECODE_OBJECT              = 4'h8,
    MCD_CMD_MPEG2_PICTURE_STATE            = 4'h9,
    MCD_CMD_MPEG2_QUANT_MATRIX_STATE       = 4'ha,
    MCD_CMD_MPEG2_DECODE_OBJECT            = 4'hb
  } mcd_cmd_t;

  typedef enum logic [1:0] {
    MCD_LVL_NONE  = 2'h0,
    MCD_LVL_IMAGE = 2'h1,
    MCD_LVL_SLICE = 2'h2
  } mcd_level_t;

  typedef struct packed {
    logic [1:0] pipe_type;
    logic [2:0] opcode;
    logic [2:0] sub_opcode_a;
    logic [4:0] sub_opcode_b;
  } mcd_fields_t;

  typedef struct packed {
    mcd_cmd_t         cmd;
    mcd_level_t       level;
    logic             interruptible;
    logic             invalid;
    logic             unhandled;
    logic             start;
    logic [HDR_W-1:0] header;
  } mcd_result_t;

endpackage : mcd_pkg

// [verification/mcd_decoder_asserts.sv]
`timescale 1ns/10ps
module mcd_decoder_asserts
  import mcd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hdr_valid,
  input wire logic [31:0] hdr_data,
  input wire logic        hdr_ready,
  input wire logic        res_valid,
  input wire logic        res_ready,
  input mcd_result_t      res
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [12:0] f = res.header[28:16];
  a_take_answer: assert property (hdr_valid && hdr_ready |=> res_valid && res.header == $past(hdr_data))
    else $error("header not answered next cycle");
  a_refuse_busy: assert property (res_valid && !res_ready |-> !hdr_ready ##1 $stable(res))
    else $error("result not held under backpressure");
  a_inv_nostart: assert property (res_valid && res.invalid |-> !res.start)
    else $error("invalid command started");
  a_avc_dec: assert property (res_valid && f == {2'h2, 3'h1, 3'h1, 5'h08} |->
    res.cmd == MCD_CMD_AVC_DECODE_OBJECT && !res.interruptible) else $error("avc decode");
  a_pack_intr: assert property (res_valid && f == {2'h2, 3'h1, 3'h2, 5'h09} |->
    res.cmd == MCD_CMD_AVC_ENC_PACK_OBJECT && res.interruptible) else $error("pack");
  a_vc1_dec: assert property (res_valid && f == {2'h2, 3'h2, 3'h1, 5'h08} |->
    res.cmd == MCD_CMD_VC1_DECODE_OBJECT && res.interruptible) else $error("vc1 decode");
  a_vc1_enc: assert property (res_valid && f[12:5] == {2'h2, 3'h2, 3'h2} |-> res.invalid)
    else $error("vc1 encode group not reserved");
  a_mpeg2_enc: assert property (res_valid && f[12:5] == {2'h2, 3'h3, 3'h2} |-> res.invalid)
    else $error("mpeg2 encode group not reserved");
  a_rsvd_opcode: assert property (res_valid && f[12:11] == 2'h2 && f[10:8] inside {3'h4, 3'h5, 3'h7}
    |-> res.invalid && !res.start) else $error("reserved opcode accepted");
endmodule : mcd_decoder_asserts

bind mcd_decoder mcd_decoder_asserts u_mcd_decoder_asserts (.clk(clk), .rst(rst),
  .hdr_valid(hdr_valid), .hdr_data(hdr_data), .hdr_ready(hdr_ready),
  .res_valid(res_valid), .res_ready(res_ready), .res(res));

// [verification/mcd_decoder_tb.sv]
`timescale 1ns/10ps
module mcd_decoder_tb;
  import mcd_pkg::*;
  logic        clk, rst, load, hdr_valid, hdr_ready, res_valid, res_ready;
  logic [31:0] word, hdr_data;
  mcd_result_t res;
  int          num_errors, total_checks;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  mcd_streamer_model u_mcd_streamer_model (.clk(clk), .rst(rst), .load(load), .word(word),
    .hdr_ready(hdr_ready), .hdr_valid(hdr_valid), .hdr_data(hdr_data));
  mcd_decoder u_mcd_decoder (.clk(clk), .rst(rst), .hdr_valid(hdr_valid), .hdr_data(hdr_data),
    .hdr_ready(hdr_ready), .res_valid(res_valid), .res_ready(res_ready), .res(res));
  // Ignored top bits and low payload set so field slicing is exercised
  function automatic logic [31:0] h(input logic [2:0] op, a, input logic [4:0] b);
    return {3'h5, 2'h2, op, a, b, 16'ha5c3};
  endfunction : h
  task automatic results;
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input logic [31:0] w);
    load <= 1'b1;
    word <= w;
    @(posedge clk);
    load <= 1'b0;
  endtask : send
  // Expected: cmd, level, interruptible, invalid, start
  task automatic run(input logic [31:0] w, input logic [8:0] exp);
    int n;
    n = 0;
    send(w);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (res_valid !== 1'b1 && n < 20);
    check({res.cmd, res.level, res.interruptible, res.invalid, res.start}, exp);
    check(res.header, w);
    check(res.unhandled, exp == 9'h0);
    @(posedge clk);
  endtask : run
  // Reset lands while a result is pending; the slot must come back empty
  task automatic t_reset;
    res_ready <= 1'b0;
    send(h(3'h2, 3'h1, 5'h08));
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst       <= 1'b0;
    res_ready <= 1'b1;
    @(posedge clk);
    #1;
    check({hdr_ready, res_valid}, 32'h2);
    check(res.header, 32'h0);
    @(posedge clk);
  endtask : t_reset
  task automatic t_hold;
    res_ready <= 1'b0;
    send(h(3'h1, 3'h2, 5'h09));
    @(posedge clk);
    send(h(3'h3, 3'h1, 5'h08));
    repeat (3) begin
      @(posedge clk);
      #1;
      check(hdr_ready, 32'h0);
      check(res.header, h(3'h1, 3'h2, 5'h09));
    end
    @(posedge clk);
    res_ready <= 1'b1;
    @(posedge clk);
    #1;
    check(res.header, h(3'h3, 3'h1, 5'h08));
    @(posedge clk);
  endtask : t_hold
  initial begin
    #20000;
    num_errors++;
    results;
  end
  initial begin
    rst = 1'b1;
    load = 1'b0;
    word = 32'h0;
    res_ready = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({hdr_ready, res_valid}, 32'h2);
    @(posedge clk);
    run(h(3'h1, 3'h1, 5'h08), 9'h021);
    run(h(3'h1, 3'h1, 5'h07), 9'h002);
    run(h(3'h1, 3'h2, 5'h02), 9'h049);
    run(h(3'h1, 3'h2, 5'h08), 9'h061);
    run(h(3'h1, 3'h2, 5'h09), 9'h085);
    run(h(3'h1, 3'h2, 5'h0a), 9'h002);
    run(h(3'h2, 3'h0, 5'h00), 9'h0a9);
    run(h(3'h2, 3'h0, 5'h01), 9'h0c9);
    run(h(3'h2, 3'h0, 5'h02), 9'h0f1);
    run(h(3'h2, 3'h1, 5'h08), 9'h105);
    run(h(3'h2, 3'h2, 5'h00), 9'h002);
    run(h(3'h2, 3'h2, 5'h1f), 9'h002);
    run(h(3'h3, 3'h0, 5'h00), 9'h129);
    run(h(3'h3, 3'h0, 5'h01), 9'h149);
    run(h(3'h3, 3'h0, 5'h02), 9'h002);
    run(h(3'h3, 3'h1, 5'h08), 9'h165);
    run(h(3'h3, 3'h2, 5'h05), 9'h002);
    run(h(3'h4, 3'h3, 5'h03), 9'h002);
    run(h(3'h5, 3'h0, 5'h00), 9'h002);
    run(h(3'h7, 3'h7, 5'h1f), 9'h002);
    run(h(3'h0, 3'h0, 5'h00), 9'h000);
    t_reset;
    t_hold;
    results;
  end
endmodule : mcd_decoder_tb

// [verification/mcd_streamer_model.sv]
`timescale 1ns/10ps
module mcd_streamer_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [31:0] word,
  input  wire logic        hdr_ready,
  output logic             hdr_valid,
  output logic [31:0]      hdr_data
);
  // Released bus shows the inverse so a late sample cannot look right
  always_ff @(posedge clk) begin
    if (rst) begin
      hdr_valid <= 1'b0;
      hdr_data  <= 32'h0;
    end else if (hdr_valid && hdr_ready) begin
      hdr_valid <= 1'b0;
      hdr_data  <= ~hdr_data;
    end else if (!hdr_valid && load) begin
      hdr_valid <= 1'b1;
      hdr_data  <= word;
    end
  end
endmodule : mcd_streamer_model
